//--- sim/action_ctl_checker.sv
// Port checker for the action control block
`timescale 1ns/1ns
`default_nettype none
module action_ctl_checker #(
  parameter int CAL_CYC = action_ctl_pkg::CAL_CYCLES
) (
  // Clock, reset and APB
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [13:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic PREADY_O,
  // Actions and flags
  input wire logic DIST_STALL_O,
  input wire logic DIST_SYNC_O,
  input wire logic CORE_CLK_HOLD_O,
  input wire action_ctl_pkg::func_pulse_t FUNC_PULSE_O,
  input wire logic [action_ctl_pkg::NUM_FLAGS-1:0] EVENT_FLAGS_O
);
  import action_ctl_pkg::*;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  // ==========================================================
  // Helpers
  int hold_cnt_q;
  wire logic fr_wr = PSEL_I && PENABLE_I && PWRITE_I
    && PADDR_I == ADDR_FUNC_RST;
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) hold_cnt_q <= 0;
    else hold_cnt_q <= CORE_CLK_HOLD_O ? hold_cnt_q + 1 : 0;
  end
  // ==========================================================
  // Properties
  property p_rdy; PSEL_I && !PENABLE_I |=> PREADY_O; endproperty
  a_rdy: assert property (p_rdy) else $error("no zero wait answer");
  property p_rdy1; PREADY_O |=> !PREADY_O; endproperty
  a_rdy1: assert property (p_rdy1) else $error("ready too long");
  property p_stall; DIST_SYNC_O |-> !DIST_STALL_O; endproperty
  a_stall: assert property (p_stall) else $error("sync while stalled");
  property p_sfall; $fell(DIST_STALL_O) |-> ##[0:2] DIST_SYNC_O; endproperty
  a_sfall: assert property (p_sfall) else $error("no sync on fall");
  property p_p1; FUNC_PULSE_O != 5'h00 |=> FUNC_PULSE_O == 5'h00; endproperty
  a_p1: assert property (p_p1) else $error("pulse not cleared");
  // Pulse must follow the very next cycle, carrying the written bits
  property p_fmap;
    fr_wr |=> FUNC_PULSE_O == $past(PWDATA_I[6:2]);
  endproperty
  a_fmap: assert property (p_fmap) else $error("pulse map");
  property p_hlen;
    $fell(CORE_CLK_HOLD_O) |-> hold_cnt_q inside {[CAL_CYC-1:CAL_CYC+1]};
  endproperty
  a_hlen: assert property (p_hlen) else $error("cal length");
  property p_cdone;
    $fell(CORE_CLK_HOLD_O) |-> ##[0:2] EVENT_FLAGS_O[1];
  endproperty
  a_cdone: assert property (p_cdone) else $error("no cal done flag");
  property p_unused;
    EVENT_FLAGS_O[3:2] == 2'b00 && EVENT_FLAGS_O[7:6] == 2'b00;
  endproperty
  a_unused: assert property (p_unused) else $error("unused flag set");
  c_sync: cover property (DIST_SYNC_O);
  c_cal: cover property ($fell(CORE_CLK_HOLD_O));
  c_fr: cover property (fr_wr);
endmodule // action_ctl_checker
`default_nettype wire

//--- sim/action_ctl_tb.sv
// Self-checking bench for the action control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((e) !== (s)) begin err_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module action_ctl_tb;
  import action_ctl_pkg::*;
  // Short counts keep the run brief
  localparam int CAL_CYC = 20;
  localparam int WDOG_CYC = 16;
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic pll_en = 1'b0, lock = 1'b0, sfault = 1'b0, sdone = 1'b0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic pready, pslverr, stall, dsync, hold, rde;
  logic [31:0] prdata, rdv;
  func_pulse_t fp;
  logic [NUM_FLAGS-1:0] fl;
  logic [4:0] fp_acc = 5'h00;
  int nsync = 0;
  int err_count = 0;
  int checks = 0;
  always #4 clk = ~clk;
  // Sync pulse lasts one cycle, so count it
  always @(posedge clk) begin
    if (dsync === 1'b1) nsync++;
  end
  action_ctl #(.CAL_CYC(CAL_CYC), .WDOG_CYC(WDOG_CYC)) dut (
    .CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .PRDATA_O(prdata), .PLL_EN_I(pll_en),
    .PLL_LOCK_I(lock), .STORE_FAULT_I(sfault), .STORE_DONE_I(sdone),
    .DIST_STALL_O(stall), .DIST_SYNC_O(dsync), .CORE_CLK_HOLD_O(hold),
    .FUNC_PULSE_O(fp), .EVENT_FLAGS_O(fl));
  // ==========================================================
  // Bus and helpers
  task automatic apb(input logic w, input logic [13:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    `CHK("pready", 1'b1, pready)
    `CHK("wait", 1, n)
    rdv = prdata;
    rde = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wait_c(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Pulses last one cycle, so gather them over a span
  task automatic collect(input int n);
    fp_acc = 5'h00;
    repeat (n) begin
      @(posedge clk);
      fp_acc = fp_acc | fp;
    end
    #1;
  endtask
  task automatic cal_seq();
    apb(1'b1, ADDR_CAL_SYNC, 32'h0000_0000);
    apb(1'b1, ADDR_COMMIT, 32'h0000_0001);
    apb(1'b1, ADDR_CAL_SYNC, 32'h0000_0001);
    apb(1'b1, ADDR_COMMIT, 32'h0000_0001);
    wait_c(3);
  endtask
  task automatic close_out();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    `CHK("flags", 12'h000, fl)
    apb(1'b0, ADDR_CAL_SYNC, 32'h0000_0000);
    `CHK("cal_sync", 32'h0000_0000, rdv)
    apb(1'b0, 14'h0000, 32'h0000_0000);
    `CHK("slverr", 1'b1, rde)
  endtask
  task automatic t_sync();
    apb(1'b1, ADDR_CAL_SYNC, 32'h0000_0002);
    wait_c(3);
    `CHK("stall", 1'b1, stall)
    `CHK("sync_early", 0, nsync)
    apb(1'b1, ADDR_CAL_SYNC, 32'h0000_0000);
    wait_c(3);
    `CHK("sync", 1, nsync)
    `CHK("sync_flag", 1'b1, fl[11])
    apb(1'b1, ADDR_AUX_CLR, 32'h0000_0008);
    wait_c(3);
    `CHK("sync_clr", 1'b0, fl[11])
  endtask
  task automatic t_func();
    for (int i = FR_TW_HIST; i <= FR_LOOP; i++) begin
      apb(1'b1, ADDR_FUNC_RST, 32'h0000_0001 << i);
      collect(4);
      `CHK("pulse", 5'h01 << (i - FR_TW_HIST), fp_acc)
      `CHK("pulse_end", 5'h00, fp)
    end
    apb(1'b1, ADDR_FUNC_RST, 32'h0000_0000);
    collect(4);
    `CHK("zero_wr", 5'h00, fp_acc)
    apb(1'b0, ADDR_FUNC_RST, 32'h0000_0000);
    `CHK("fr_read", 32'h0000_0000, rdv)
  endtask
  task automatic t_cal();
    cal_seq();
    `CHK("cal_off", 1'b0, hold)
    @(posedge clk);
    pll_en <= 1'b1;
    cal_seq();
    `CHK("cal_run", 1'b1, hold)
    `CHK("cal_start", 1'b1, fl[0])
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    `CHK("status_run", 1'b1, rdv[12])
    wait_c(CAL_CYC + 4);
    `CHK("cal_end", 1'b0, hold)
    `CHK("cal_done", 1'b1, fl[1])
    apb(1'b1, ADDR_COMMIT, 32'h0000_0001);
    wait_c(3);
    `CHK("recal", 1'b0, hold)
    apb(1'b1, ADDR_SYS_CLR, 32'h0000_0003);
    wait_c(3);
    `CHK("cal_clr", 2'b00, fl[1:0])
  endtask
  task automatic t_evt();
    @(posedge clk);
    lock <= 1'b1;
    sdone <= 1'b1;
    @(posedge clk);
    sdone <= 1'b0;
    sfault <= 1'b1;
    @(posedge clk);
    sfault <= 1'b0;
    lock <= 1'b0;
    apb(1'b1, ADDR_SYS_CLR, 32'h0000_0000);
    apb(1'b1, ADDR_AUX_CLR, 32'h0000_0000);
    wait_c(3);
    `CHK("zero_clr", 4'hf, {fl[9:8], fl[5:4]})
    apb(1'b1, ADDR_SYS_CLR, 32'h0000_0030);
    apb(1'b1, ADDR_AUX_CLR, 32'h0000_0003);
    wait_c(3);
    `CHK("evt_clr", 4'h0, {fl[9:8], fl[5:4]})
  endtask
  task automatic t_wdog();
    apb(1'b1, ADDR_FUNC_RST, 32'h0000_0001);
    apb(1'b1, ADDR_AUX_CLR, 32'h0000_0004);
    repeat (6) apb(1'b1, ADDR_FUNC_RST, 32'h0000_0001);
    `CHK("wd_kick", 1'b0, fl[10])
    lock <= 1'b1;
    wait_c(WDOG_CYC + 4);
    `CHK("wd_expire", 1'b1, fl[10])
    apb(1'b1, ADDR_FUNC_RST, 32'h0000_0003);
    wait_c(3);
    `CHK("all_clr", 12'h000, fl)
  endtask
  // ==========================================================
  // Sequence and watchdog
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    close_out();
  end
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    wait_c(1);
    t_reset();
    t_sync();
    t_func();
    t_cal();
    t_evt();
    t_wdog();
    close_out();
  end
endmodule // action_ctl_tb
bind action_ctl action_ctl_checker #(.CAL_CYC(CAL_CYC)) chk (
  .CLK_I(CLK_I), .NRST_I(NRST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
  .PREADY_O(PREADY_O), .DIST_STALL_O(DIST_STALL_O),
  .DIST_SYNC_O(DIST_SYNC_O), .CORE_CLK_HOLD_O(CORE_CLK_HOLD_O),
  .FUNC_PULSE_O(FUNC_PULSE_O), .EVENT_FLAGS_O(EVENT_FLAGS_O));
`default_nettype wire

//--- verilog/action_ctl.sv
// Self-acting control and event clear registers over APB
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module action_ctl #(
  parameter int CAL_CYC = action_ctl_pkg::CAL_CYCLES,
  parameter int WDOG_CYC = action_ctl_pkg::WDOG_PERIOD_CYC
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [13:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic [31:0] PRDATA_O,
  // Core PLL and external event sources
  input wire logic PLL_EN_I,
  input wire logic PLL_LOCK_I,
  input wire logic STORE_FAULT_I,
  input wire logic STORE_DONE_I,
  // Function actions
  output logic DIST_STALL_O,
  output logic DIST_SYNC_O,
  output logic CORE_CLK_HOLD_O,
  output action_ctl_pkg::func_pulse_t FUNC_PULSE_O,
  // Event flags
  output logic [action_ctl_pkg::NUM_FLAGS-1:0] EVENT_FLAGS_O
);
  import action_ctl_pkg::*;

  // ==========================================================
  // Bus decode
  apb_req_t req;
  assign req = '{PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I};
  wire access = req.psel & req.penable;
  wire wr = access & req.pwrite;
  wire rd = access & ~req.pwrite;
  wire hit_cal = (req.paddr == ADDR_CAL_SYNC);
  wire hit_func = (req.paddr == ADDR_FUNC_RST);
  wire hit_sys = (req.paddr == ADDR_SYS_CLR);
  wire hit_aux = (req.paddr == ADDR_AUX_CLR);
  wire hit_commit = (req.paddr == ADDR_COMMIT);
  wire hit_stat = (req.paddr == ADDR_STATUS);
  wire hit_any = hit_cal | hit_func | hit_sys | hit_aux | hit_commit
    | hit_stat;
  wire [7:0] wbyte = req.pwdata[7:0];
  wire wr_cal = wr & hit_cal;
  wire wr_func = wr & hit_func;
  wire wr_sys = wr & hit_sys;
  wire wr_aux = wr & hit_aux;
  wire commit = wr & hit_commit & wbyte[COMMIT_BIT];

  // ==========================================================
  // One-shot actions; zero writes leave everything alone
  wire [7:0] func_act = wr_func ? (wbyte & FUNC_RST_MASK) : 8'h00;
  wire [7:0] sys_act = wr_sys ? (wbyte & SYS_CLR_MASK) : 8'h00;
  wire [7:0] aux_act = wr_aux ? (wbyte & AUX_CLR_MASK) : 8'h00;
  wire all_clr = func_act[FR_ALL_IRQ];
  wire kick = func_act[FR_WDOG];

  // Flag layout mirrors the clear layout: sys low byte bits, aux above
  wire [NUM_FLAGS-1:0] clr_vec;
  assign clr_vec = {aux_act[3:0], sys_act}
    | {NUM_FLAGS{all_clr}};

  // ==========================================================
  // Control register
  logic [7:0] cal_sync_q;
  logic sync_prev_q;
  logic lock_prev_q;
  logic [NUM_FLAGS-1:0] flags_q;
  logic [NUM_FLAGS-1:0] set_vec;
  logic cal_run;
  logic cal_start;
  logic cal_done;
  logic wd_timeout;

  wire sync_fall = sync_prev_q & ~cal_sync_q[SYNC_BIT];

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cal_sync_q <= CAL_SYNC_RST;
      sync_prev_q <= 1'b0;
      lock_prev_q <= 1'b0;
    end else begin
      if (wr_cal) cal_sync_q <= wbyte & CAL_SYNC_MASK;
      sync_prev_q <= cal_sync_q[SYNC_BIT];
      lock_prev_q <= PLL_LOCK_I;
    end
  end

  // ==========================================================
  // Calibration and watchdog
  pll_cal_seq #(
    .CAL_CYC(CAL_CYC)
  ) u_cal (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .cal_bit_i(cal_sync_q[CAL_BIT]),
    .commit_i(commit),
    .pll_en_i(PLL_EN_I),
    .running_o(cal_run),
    .started_o(cal_start),
    .done_o(cal_done)
  );

  // Watchdog freezes with the core clock during calibration
  wdog_timer #(
    .PERIOD(WDOG_CYC)
  ) u_wdog (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .kick_i(kick),
    .hold_i(cal_run),
    .timeout_o(wd_timeout)
  );

  // ==========================================================
  // Event flags: set wins over clear
  assign set_vec = {
    sync_fall, wd_timeout, STORE_FAULT_I, STORE_DONE_I,
    2'b00,
    ~PLL_LOCK_I & lock_prev_q,
    PLL_LOCK_I & ~lock_prev_q,
    2'b00,
    cal_done,
    cal_start
  };

  genvar g;
  generate
    for (g = 0; g < NUM_FLAGS; g++) begin : g_flag
      always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) flags_q[g] <= 1'b0;
        else if (set_vec[g]) flags_q[g] <= 1'b1;
        else if (clr_vec[g]) flags_q[g] <= 1'b0;
      end
    end
  endgenerate

  // ==========================================================
  // Outputs, all registered
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      DIST_STALL_O <= 1'b0;
      DIST_SYNC_O <= 1'b0;
      CORE_CLK_HOLD_O <= 1'b0;
      FUNC_PULSE_O <= '0;
      EVENT_FLAGS_O <= '0;
    end else begin
      DIST_STALL_O <= cal_sync_q[SYNC_BIT];
      DIST_SYNC_O <= sync_fall;
      CORE_CLK_HOLD_O <= cal_run;
      // Pulses last one cycle; nothing is stored, so no write-back needed
      FUNC_PULSE_O <= '{func_act[FR_LOOP],
        func_act[FR_CIC],
        func_act[FR_PHASE_ACC],
        func_act[FR_AUTO_SYNC],
        func_act[FR_TW_HIST]};
      EVENT_FLAGS_O <= flags_q;
    end
  end

  // ==========================================================
  // APB answer: one access cycle, no wait states
  wire [31:0] rd_mux =
    hit_cal ? {24'h00_0000, cal_sync_q} :
    hit_stat ? {19'h0_0000, cal_run, flags_q} :
    RD_ZERO;

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= RD_ZERO;
    end else begin
      PREADY_O <= req.psel & ~req.penable;
      PSLVERR_O <= req.psel & ~req.penable & ~hit_any;
      PRDATA_O <= (req.psel & ~req.penable & ~req.pwrite) ? rd_mux : RD_ZERO;
    end
  end

  wire unused_rd = rd;
endmodule // action_ctl
`default_nettype wire

//--- verilog/action_ctl_pkg.sv
// Package: register map, field positions and timing for the action controls
package action_ctl_pkg;

  // ==========================================================
  // Register indices; each byte address is four times its index
  localparam logic [11:0] IDX_CAL_SYNC = 12'h0a02;
  localparam logic [11:0] IDX_FUNC_RST = 12'h0a03;
  localparam logic [11:0] IDX_SYS_CLR = 12'h0a04;
  localparam logic [11:0] IDX_AUX_CLR = 12'h0a05;
  localparam logic [11:0] IDX_COMMIT = 12'h0a10;
  localparam logic [11:0] IDX_STATUS = 12'h0a11;
  localparam logic [13:0] ADDR_CAL_SYNC = {IDX_CAL_SYNC, 2'b00};
  localparam logic [13:0] ADDR_FUNC_RST = {IDX_FUNC_RST, 2'b00};
  localparam logic [13:0] ADDR_SYS_CLR = {IDX_SYS_CLR, 2'b00};
  localparam logic [13:0] ADDR_AUX_CLR = {IDX_AUX_CLR, 2'b00};
  localparam logic [13:0] ADDR_COMMIT = {IDX_COMMIT, 2'b00};
  localparam logic [13:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

  // ==========================================================
  // Field positions
  localparam int CAL_BIT = 0;
  localparam int SYNC_BIT = 1;
  localparam int FR_WDOG = 0;
  localparam int FR_ALL_IRQ = 1;
  localparam int FR_TW_HIST = 2;
  localparam int FR_AUTO_SYNC = 3;
  localparam int FR_PHASE_ACC = 4;
  localparam int FR_CIC = 5;
  localparam int FR_LOOP = 6;
  localparam int COMMIT_BIT = 0;
  localparam int NUM_FLAGS = 12;

  // ==========================================================
  // Writable masks and reset values
  localparam logic [7:0] CAL_SYNC_MASK = 8'h03;
  localparam logic [7:0] FUNC_RST_MASK = 8'h7f;
  localparam logic [7:0] SYS_CLR_MASK = 8'h33;
  localparam logic [7:0] AUX_CLR_MASK = 8'h0f;
  localparam logic [7:0] CAL_SYNC_RST = 8'h00;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 125;
  localparam int CAL_TIME_US = 2000;
  localparam int CAL_CYCLES = CAL_TIME_US * CLK_MHZ;
  localparam int WDOG_PERIOD_CYC = 1000;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic clr_loop;
    logic clr_cic;
    logic clr_phase_acc;
    logic rst_auto_sync;
    logic rst_tw_hist;
  } func_pulse_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [13:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_ARMED = 3'b010,
    CAL_RUN = 3'b100
  } cal_state_t;

endpackage

//--- verilog/pll_cal_seq.sv
// Calibration sequencer for the core timebase PLL
`timescale 1ns/1ns
`default_nettype none
module pll_cal_seq #(
  parameter int CAL_CYC = 250000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Control
  input wire logic cal_bit_i,
  input wire logic commit_i,
  input wire logic pll_en_i,
  // Status
  output logic running_o,
  output logic started_o,
  output logic done_o
);
  import action_ctl_pkg::*;

  cal_state_t state_q;
  cal_state_t state_d;
  logic cal_prev_q;
  logic [31:0] cnt_q;
  wire rise = cal_bit_i & ~cal_prev_q;
  wire cnt_end = (cnt_q == 32'(CAL_CYC - 1));
  wire go = (state_q == CAL_ARMED) & commit_i & pll_en_i;

  // ==========================================================
  // Arm on rising bit, launch on commit while the PLL is enabled
  always_comb begin
    state_d = state_q;
    case (state_q)
      CAL_IDLE: if (rise) state_d = CAL_ARMED;
      CAL_ARMED: begin
        if (!cal_bit_i) state_d = CAL_IDLE;
        else if (go) state_d = CAL_RUN;
      end
      CAL_RUN: if (cnt_end) state_d = CAL_IDLE;
      default: state_d = CAL_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= CAL_IDLE;
      cal_prev_q <= 1'b0;
      cnt_q <= 32'h0000_0000;
      started_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      state_q <= state_d;
      cal_prev_q <= cal_bit_i;
      // Band and amplitude search is internal; only duration is modelled
      cnt_q <= (state_q == CAL_RUN) ? cnt_q + 32'h0000_0001
        : 32'h0000_0000;
      started_o <= go;
      done_o <= (state_q == CAL_RUN) & cnt_end;
    end
  end

  assign running_o = (state_q == CAL_RUN);
endmodule // pll_cal_seq
`default_nettype wire

//--- verilog/wdog_timer.sv
// Watchdog timer with software restart
`timescale 1ns/1ns
`default_nettype none
module wdog_timer #(
  parameter int PERIOD = 1000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Control
  input wire logic kick_i,
  input wire logic hold_i,
  // Event
  output logic timeout_o
);
  logic [31:0] cnt_q;
  wire at_end = (cnt_q == 32'(PERIOD - 1));

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= 32'h0000_0000;
      timeout_o <= 1'b0;
    end else begin
      // Kick wins over expiry, so no event on a kicked cycle
      if (kick_i) cnt_q <= 32'h0000_0000;
      else if (hold_i) cnt_q <= cnt_q;
      else if (at_end) cnt_q <= 32'h0000_0000;
      else cnt_q <= cnt_q + 32'h0000_0001;
      timeout_o <= at_end & ~kick_i & ~hold_i;
    end
  end
endmodule // wdog_timer
`default_nettype wire
